// file: src/dpm_pkg.sv
// Constants for the host-side port controller of the dual-port mailbox RAM.
package dpm_pkg;
   localparam int          ADDR_W          = 14;
   localparam int          DATA_W          = 9;
   localparam int          TOKEN_W         = 3;
   localparam logic [13:0] MAIL_LEFT_ADDR  = 14'h3ffe;
   localparam logic [13:0] MAIL_RIGHT_ADDR = 14'h3fff;
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          T_SETTLE_NS     = 300;
   localparam int          T_STROBE_NS     = 300;
   localparam int          SETTLE_CYC      = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          STROBE_CYC      = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  SETTLE_LOAD     = 4'(SETTLE_CYC - 1);
   localparam logic [3:0]  STROBE_LOAD     = 4'(STROBE_CYC - 1);
   localparam logic [2:0]  ST_IDLE         = 3'h0;
   typedef enum logic [2:0] {
      DPM_IDLE    = 3'b000,
      DPM_SETUP   = 3'b001,
      DPM_SETTLE  = 3'b010,
      DPM_STROBE  = 3'b011,
      DPM_RELEASE = 3'b100
   } dpm_state_t;
endpackage

// file: src/dpm_sync.sv
// Two-flop synchroniser for levels arriving from the RAM pins.
`timescale 1ns/10ps
module dpm_sync #(
   parameter int W          = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input  wire logic         sys_clk, // System clock.
   input  wire logic         rst_n,   // Asynchronous reset, active low.
   input  wire logic [W-1:0] async_i, // Level from outside the clock domain.
   output logic      [W-1:0] sync_o   // Level safe for logic.
);
   logic [W-1:0] meta_q;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= INIT;
         sync_o <= INIT;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// file: src/dpm_host.sv
// Host controller that drives one port of the dual-port mailbox RAM through its pins.
//
// Contract
// - Host holds follower collision input high, or low to block writes.
// - Depth expansion ANDs the parts' collision flags externally.
// - Width expansion uses exactly one lead; all others follow.
// - Hold address and select until collision settles before the write pulse.
// - Token select low reaches semaphores; three low address bits pick one.
`timescale 1ns/10ps
module dpm_host
   import dpm_pkg::*;
(
   input  wire logic              sys_clk,          // System clock, 10 MHz.
   input  wire logic              rst_n,            // Asynchronous reset, active low.
   input  wire logic              cmd_valid,        // Request an access.
   input  wire logic              cmd_write,        // High for write, low for read.
   input  wire logic              cmd_token,        // High to access the semaphore space.
   input  wire logic [ADDR_W-1:0] cmd_addr,         // Word address, or token index in low bits.
   input  wire logic [DATA_W-1:0] cmd_wdata,        // Write data; bit 0 is the token value.
   input  wire logic              cmd_block_writes, // Hold the follower write inhibit low.
   output logic                   cmd_ready,        // Controller idle, request taken.
   output logic                   rsp_valid,        // One-cycle pulse when an access ends.
   output logic      [DATA_W-1:0] rsp_rdata,        // Read data of the last read.
   output logic                   rsp_stalled,      // Write held back by a collision flag.
   output logic                   mail_pending,     // Our mail flag is asserted.
   output logic                   port_select_n,    // RAM array select, active low.
   output logic                   token_select_n,   // Semaphore space select, active low.
   output logic                   write_strobe_n,   // Write strobe, active low.
   output logic                   output_drive_n,   // Output drive request, active low.
   output logic      [ADDR_W-1:0] addr_o,           // Address pins.
   output logic      [DATA_W-1:0] data_o,           // Data pins, driven value.
   output logic                   data_oe,          // Data pins enable, high while we drive.
   input  wire logic [DATA_W-1:0] data_i,           // Data pins, sensed value.
   input  wire logic              collision_flag_n, // Collision flag from the lead part.
   input  wire logic              mail_flag_n,      // Our mail flag from the RAM.
   output logic                   collision_hold_n  // Follower write inhibit level.
);
   dpm_state_t        state_q;
   dpm_state_t        state_d;
   logic [3:0]        cnt_q;
   logic [3:0]        cnt_d;
   logic              wr_q;
   logic              tok_q;
   logic [DATA_W-1:0] data_s;
   logic              busy_s;
   logic              mail_s;

   // All pin inputs pass two flops before any logic looks at them.
   dpm_sync #(.W(DATA_W), .INIT('0)) u_sync_data (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .async_i (data_i),
      .sync_o  (data_s)
   );
   // One collision input serves: depth-expanded arrays AND their flags onto it, and wide
   // arrays send only the single lead's flag, so split decisions never reach this controller.
   dpm_sync #(.W(2), .INIT(2'h3)) u_sync_flags (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .async_i ({collision_flag_n, mail_flag_n}),
      .sync_o  ({busy_s, mail_s})
   );

   // Decode of the sequencer steps.
   wire take_cmd    = (state_q == DPM_IDLE) && cmd_valid;
   wire cnt_done    = (cnt_q == 4'h0);
   wire wr_blocked  = wr_q && !tok_q && !busy_s;
   wire settle_end  = (state_q == DPM_SETTLE) && cnt_done && !wr_blocked;
   wire strobe_end  = (state_q == DPM_STROBE) && cnt_done;
   wire [ADDR_W-1:0] pin_addr = cmd_token ? {{(ADDR_W-TOKEN_W){1'b0}}, cmd_addr[TOKEN_W-1:0]}
                                          : cmd_addr;
   wire [DATA_W-1:0] pin_wdata = cmd_token ? {DATA_W{cmd_wdata[0]}} : cmd_wdata;

   // Next state; a collided write waits in settle rather than pulsing into a gated write.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_done ? 4'h0 : cnt_q - 4'h1;
      unique case (state_q)
         DPM_IDLE: begin
            cnt_d = 4'h0;
            if (cmd_valid) begin
               state_d = DPM_SETUP;
            end
         end
         DPM_SETUP: begin
            state_d = DPM_SETTLE;
            cnt_d   = SETTLE_LOAD;
         end
         DPM_SETTLE: begin
            if (settle_end) begin
               state_d = DPM_STROBE;
               cnt_d   = STROBE_LOAD;
            end
         end
         DPM_STROBE: begin
            if (strobe_end) begin
               state_d = DPM_RELEASE;
            end
         end
         DPM_RELEASE: begin
            state_d = DPM_IDLE;
         end
         default: begin
            state_d = DPM_IDLE;
         end
      endcase
   end

   // Sequencer registers and latched request.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= DPM_IDLE;
         cnt_q   <= 4'h0;
         wr_q    <= 1'b0;
         tok_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         if (take_cmd) begin
            wr_q  <= cmd_write;
            tok_q <= cmd_token;
         end
      end
   end

   // Address and write data are set once per request and stay put through the strobe.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_o <= '0;
         data_o <= '0;
      end else if (take_cmd) begin
         addr_o <= pin_addr;
         data_o <= pin_wdata;
      end
   end

   // Selects are held from setup to release, so both are high in idle for standby.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         port_select_n  <= 1'b1;
         token_select_n <= 1'b1;
         data_oe        <= 1'b0;
      end else if (take_cmd) begin
         port_select_n  <= cmd_token;
         token_select_n <= !cmd_token;
         data_oe        <= cmd_write;
      end else if (state_q == DPM_RELEASE) begin
         port_select_n  <= 1'b1;
         token_select_n <= 1'b1;
         data_oe        <= 1'b0;
      end
   end

   // Strobes open only after the collision flag has had time to settle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_strobe_n <= 1'b1;
         output_drive_n <= 1'b1;
      end else if (settle_end) begin
         write_strobe_n <= !wr_q;
         output_drive_n <= wr_q;
      end else if (strobe_end) begin
         write_strobe_n <= 1'b1;
         output_drive_n <= 1'b1;
      end
   end

   // Read data is taken at strobe end, after the synchroniser has caught up.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_rdata   <= '0;
         rsp_valid   <= 1'b0;
         cmd_ready   <= 1'b0;
         rsp_stalled <= 1'b0;
      end else begin
         if (strobe_end && !wr_q) begin
            rsp_rdata <= data_s;
         end
         rsp_valid   <= (state_q == DPM_RELEASE);
         cmd_ready   <= (state_d == DPM_IDLE) && !take_cmd;
         rsp_stalled <= (state_q == DPM_SETTLE) && cnt_done && wr_blocked;
      end
   end

   // Mail flag and follower inhibit levels; both registered to keep outputs glitch free.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mail_pending     <= 1'b0;
         collision_hold_n <= 1'b1;
      end else begin
         mail_pending     <= !mail_s;
         collision_hold_n <= !cmd_block_writes;
      end
   end

   // Checks on the pin sequence this controller produces.
   sequence s_strobe_hold;
      !write_strobe_n [*3] ##1 write_strobe_n;
   endsequence

   sequence s_deselect;
      port_select_n && token_select_n;
   endsequence

   property p_write_after_settle;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(write_strobe_n) |-> $past(!port_select_n || !token_select_n, 3)
                                && (!token_select_n || $past(busy_s));
   endproperty
   a_write_after_settle: assert property (p_write_after_settle)
      else $error("Write strobe opened before collision flag settled.");

   property p_addr_stable;
      @(posedge sys_clk) disable iff (!rst_n)
      !write_strobe_n |-> $stable(addr_o) && $stable(data_o);
   endproperty
   a_addr_stable: assert property (p_addr_stable)
      else $error("Address or data moved during write strobe.");

   property p_strobe_width;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(write_strobe_n) |-> s_strobe_hold;
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("Write strobe width wrong.");

   property p_one_space;
      @(posedge sys_clk) disable iff (!rst_n)
      !(port_select_n == 1'b0 && token_select_n == 1'b0);
   endproperty
   a_one_space: assert property (p_one_space)
      else $error("Both array and semaphore selected.");

   property p_token_addr;
      @(posedge sys_clk) disable iff (!rst_n)
      !token_select_n |-> addr_o[ADDR_W-1:TOKEN_W] == '0;
   endproperty
   a_token_addr: assert property (p_token_addr)
      else $error("Semaphore access drives high address bits.");

   property p_deselect_between;
      @(posedge sys_clk) disable iff (!rst_n)
      ($rose(write_strobe_n) || $rose(output_drive_n)) |=> s_deselect;
   endproperty
   a_deselect_between: assert property (p_deselect_between)
      else $error("Selects not released after access.");

   property p_no_drive_and_write;
      @(posedge sys_clk) disable iff (!rst_n)
      !(write_strobe_n == 1'b0 && output_drive_n == 1'b0);
   endproperty
   a_no_drive_and_write: assert property (p_no_drive_and_write)
      else $error("Output drive and write strobe low together.");

   property p_mail_follow;
      @(posedge sys_clk) disable iff (!rst_n)
      !mail_flag_n [*3] |=> mail_pending;
   endproperty
   a_mail_follow: assert property (p_mail_follow)
      else $error("Mail flag not reported.");

   property p_hold_level;
      @(posedge sys_clk) disable iff (!rst_n)
      cmd_block_writes |=> !collision_hold_n;
   endproperty
   a_hold_level: assert property (p_hold_level)
      else $error("Write inhibit level not held low.");

   property p_rsp_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(port_select_n && token_select_n) |-> rsp_valid ##1 !rsp_valid;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse)
      else $error("Response pulse not one cycle at release.");
endmodule

// file: tb/dpm_ram_model.sv
// Behavioural model of the dual-port RAM as seen from the left port.
`timescale 1ns/10ps
module dpm_ram_model
   import dpm_pkg::*;
(
   input  wire logic              port_select_n,    // Array select, active low.
   input  wire logic              token_select_n,   // Semaphore select, active low.
   input  wire logic              write_strobe_n,   // Write strobe, active low.
   input  wire logic              output_drive_n,   // Output drive, active low.
   input  wire logic [ADDR_W-1:0] addr,             // Address pins.
   input  wire logic [DATA_W-1:0] wdata,            // Data driven by the host.
   input  wire logic              wdata_oe,         // High while the host drives data.
   input  wire logic              busy_n,           // Collision level chosen by the bench.
   input  wire logic              hold_n,           // Follower write inhibit from the host.
   input  wire logic              peer_mail,        // Pulse: right port writes our mailbox.
   input  wire logic [7:0]        peer_token,       // Tokens held by the right port.
   output logic      [DATA_W-1:0] rdata,            // Data seen by the host.
   output logic                   mail_flag_n,      // Left mail flag.
   output logic                   collision_flag_n, // Collision level to the host.
   output logic                   peer_flag_n       // Right mail flag.
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [7:0]        held = 8'h00;
   logic [7:0]        req = 8'h00;
   logic [DATA_W-1:0] last = 9'h000;
   logic [DATA_W-1:0] sem_lat = 9'h1ff;
   wire               rd_arr = !port_select_n && !output_drive_n && write_strobe_n;
   wire               rd_sem = !token_select_n && !output_drive_n;
   wire [2:0]         idx = addr[2:0];

   // Follower mode: the bench plays the lead, so its level stands for the arbitration result.
   assign collision_flag_n = busy_n;
   // Released pins show the inverse of the last value, so stale data cannot pass.
   assign rdata = rd_sem ? sem_lat : (rd_arr ? mem[addr] : ~last);
   always @(rdata) begin
      if (rd_arr || rd_sem) last = rdata;
   end

   // Array writes end on the strobe's rising edge; a low collision level gates them.
   always @(posedge write_strobe_n) begin
      if (!port_select_n && wdata_oe && collision_flag_n && hold_n) begin
         mem[addr] = wdata;
      end
      if (!port_select_n && wdata_oe && addr == MAIL_RIGHT_ADDR) peer_flag_n = 1'b0;
      if (!token_select_n && wdata_oe) begin
         if (wdata[0] == 1'b1) begin
            held[idx] = 1'b0;
            req[idx] = 1'b0;
         end else if (!peer_token[idx]) held[idx] = 1'b1;
         else req[idx] = 1'b1;
      end
   end

   // A pending request takes the token as soon as the right port lets go.
   always @(peer_token) begin
      for (int i = 0; i < 8; i++) begin
         if (req[i] && !peer_token[i]) begin
            held[i] = 1'b1;
            req[i] = 1'b0;
         end
      end
   end

   // The read value is frozen while select and drive stay low.
   always @(negedge output_drive_n) begin
      if (!token_select_n) sem_lat = {DATA_W{!held[idx]}};
   end

   // Mail flag set by the peer, cleared by our own read of the mailbox.
   initial mail_flag_n = 1'b1;
   initial peer_flag_n = 1'b1;
   always @(posedge peer_mail or negedge output_drive_n) begin
      if (peer_mail) mail_flag_n = 1'b0;
      else if (!port_select_n && addr == MAIL_LEFT_ADDR) mail_flag_n = 1'b1;
   end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the host port controller against the RAM model.
`timescale 1ns/10ps
module testbench;
   import dpm_pkg::*;
   logic              sys_clk, rst_n, cmd_valid, cmd_write, cmd_token, cmd_block_writes;
   logic [ADDR_W-1:0] cmd_addr, addr_o;
   logic [DATA_W-1:0] cmd_wdata, rsp_rdata, data_o, data_i, rd;
   logic              cmd_ready, rsp_valid, rsp_stalled, mail_pending, port_select_n;
   logic              token_select_n, write_strobe_n, output_drive_n, data_oe;
   logic              collision_flag_n, mail_flag_n, collision_hold_n, busy_n, peer_mail;
   logic [7:0]        peer_token;
   logic              peer_flag_n;
   logic [ADDR_W-1:0] adr [5] = '{14'h0000, 14'h1555, 14'h2aaa, 14'h3ffd, 14'h3fff};
   int                err_total = 0;
   int                n_tests = 0;

   dpm_host u_dut (.sys_clk, .rst_n, .cmd_valid, .cmd_write, .cmd_token, .cmd_addr,
      .cmd_wdata, .cmd_block_writes, .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_stalled,
      .mail_pending, .port_select_n, .token_select_n, .write_strobe_n, .output_drive_n,
      .addr_o, .data_o, .data_oe, .data_i, .collision_flag_n, .mail_flag_n,
      .collision_hold_n);
   dpm_ram_model u_ram (.port_select_n, .token_select_n, .write_strobe_n, .output_drive_n,
      .addr(addr_o), .wdata(data_o), .wdata_oe(data_oe), .busy_n, .hold_n(collision_hold_n),
      .peer_mail, .peer_token, .rdata(data_i), .mail_flag_n, .collision_flag_n, .peer_flag_n);

   // Free-running 10 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One access; waits are bounded so a dead handshake cannot hang the run.
   task automatic acc(input logic w, input logic t, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_token = t;
      cmd_addr = a;
      cmd_wdata = d;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      chk("cmd_ready busy", {15'h0, cmd_ready}, 16'h0);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      chk("rsp_valid", {15'h0, rsp_valid}, 16'h1);
      rd = rsp_rdata;
      @(negedge sys_clk);
   endtask

   task automatic t_array;
      foreach (adr[i]) acc(1'b1, 1'b0, adr[i], adr[i][8:0] ^ 9'h0a5);
      foreach (adr[i]) begin
         acc(1'b0, 1'b0, adr[i], 9'h000);
         chk("array word", {7'h0, rd}, {7'h0, adr[i][8:0] ^ 9'h0a5});
      end
      chk("right mail flag", {15'h0, peer_flag_n}, 16'h0);
      chk("standby selects", {14'h0, port_select_n, token_select_n}, 16'h3);
      $display("t_array done");
   endtask

   task automatic t_mail;
      acc(1'b1, 1'b0, MAIL_LEFT_ADDR, 9'h15a);
      peer_mail = 1'b1;
      @(negedge sys_clk);
      peer_mail = 1'b0;
      repeat (5) @(negedge sys_clk);
      chk("mail_pending set", {15'h0, mail_pending}, 16'h1);
      acc(1'b0, 1'b0, MAIL_LEFT_ADDR, 9'h000);
      chk("mailbox word", {7'h0, rd}, 16'h015a);
      repeat (5) @(negedge sys_clk);
      chk("mail_pending clear", {15'h0, mail_pending}, 16'h0);
      $display("t_mail done");
   endtask

   task automatic t_busy;
      busy_n = 1'b0;
      fork
         acc(1'b1, 1'b0, 14'h0100, 9'h1c3);
         begin
            repeat (20) @(negedge sys_clk);
            chk("rsp_stalled", {15'h0, rsp_stalled}, 16'h1);
            chk("strobe held off", {15'h0, write_strobe_n}, 16'h1);
            busy_n = 1'b1;
         end
      join
      busy_n = 1'b0;
      acc(1'b0, 1'b0, 14'h0100, 9'h000);
      chk("read under collision", {7'h0, rd}, 16'h01c3);
      busy_n = 1'b1;
      $display("t_busy done");
   endtask

   task automatic t_block;
      cmd_block_writes = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("collision_hold_n low", {15'h0, collision_hold_n}, 16'h0);
      acc(1'b1, 1'b0, 14'h0100, 9'h0aa);
      acc(1'b0, 1'b0, 14'h0100, 9'h000);
      chk("blocked write", {7'h0, rd}, 16'h01c3);
      cmd_block_writes = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("collision_hold_n high", {15'h0, collision_hold_n}, 16'h1);
      acc(1'b1, 1'b0, 14'h0100, 9'h0aa);
      acc(1'b0, 1'b0, 14'h0100, 9'h000);
      chk("unblocked write", {7'h0, rd}, 16'h00aa);
      $display("t_block done");
   endtask

   task automatic t_token;
      acc(1'b1, 1'b1, 14'h0005, 9'h000);
      acc(1'b0, 1'b1, 14'h3ff5, 9'h000);
      chk("token claimed", {7'h0, rd}, 16'h0000);
      peer_token[2] = 1'b1;
      acc(1'b1, 1'b1, 14'h0002, 9'h000);
      acc(1'b0, 1'b1, 14'h0002, 9'h000);
      chk("token refused", {7'h0, rd}, 16'h01ff);
      peer_token[2] = 1'b0;
      acc(1'b0, 1'b1, 14'h0002, 9'h000);
      chk("token handed over", {7'h0, rd}, 16'h0000);
      acc(1'b1, 1'b1, 14'h0002, 9'h1ff);
      acc(1'b0, 1'b1, 14'h0002, 9'h000);
      chk("token freed", {7'h0, rd}, 16'h01ff);
      $display("t_token done");
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence; inputs change on the falling edge.
   initial begin
      {cmd_valid, cmd_write, cmd_token, cmd_block_writes, peer_mail} = 5'h00;
      {cmd_addr, cmd_wdata, peer_token} = '0;
      busy_n = 1'b1;
      rst_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      t_array();
      t_mail();
      t_busy();
      t_block();
      t_token();
      results();
   end

   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      #2000000;
      err_total++;
      results();
   end
endmodule
